// ===== shared/pxc_pkg.sv
package pxc_pkg;

	// register offsets on the internal cpu bus
	localparam logic [4:0] PXC_OFS_PA_DIR = 5'h01;
	localparam logic [4:0] PXC_OFS_PA_DATA = 5'h03;
	localparam logic [4:0] PXC_OFS_CTRL = 5'h14;
	localparam logic [4:0] PXC_OFS_PB_DATA = 5'h15;
	localparam logic [4:0] PXC_OFS_PC_DIR = 5'h16;
	localparam logic [4:0] PXC_OFS_PC_DATA = 5'h17;

	// port a direction field positions
	localparam int PXC_PA_DIR_PIN0 = 0;
	localparam int PXC_PA_DIR_HIGH = 1;

	// control register field positions
	localparam int PXC_CTL_INT_A = 0;
	localparam int PXC_CTL_INT_B = 1;
	localparam int PXC_CTL_MR = 2;
	localparam int PXC_CTL_HALT = 3;
	localparam int PXC_CTL_RAM = 6;
	localparam int PXC_CTL_STBY = 7;

	// input port pin roles
	localparam int PXC_PB_INT_A = 0;
	localparam int PXC_PB_INT_B = 1;
	localparam int PXC_PB_MR = 2;
	localparam int PXC_PB_HALT = 3;

	// reset values and fixed read values
	localparam logic [1:0] PXC_RST_PA_DIR = 2'h0;
	localparam logic [7:0] PXC_RST_PC_DIR = 8'h00;
	localparam logic [7:0] PXC_RST_PORT_DATA = 8'h00;
	localparam logic [7:0] PXC_PA_DIR_RD_FILL = 8'hFC;
	localparam logic [7:0] PXC_WO_READ = 8'hFF;
	localparam logic [7:0] PXC_UNMAPPED_READ = 8'hFF;

	// timing
	localparam int PXC_CLK_PERIOD_NS = 100;
	localparam int PXC_MR_MAX_NS = 9000;
	localparam int PXC_MR_MAX_CYC = PXC_MR_MAX_NS / PXC_CLK_PERIOD_NS;

	// pin override for port a from timer and serial unit
	typedef struct packed {
		logic [7:0] take;
		logic [7:0] dir;
		logic [7:0] dout;
	} pxc_func_s;

	// control register fields
	typedef struct packed {
		logic stby;
		logic ram_en;
		logic halt_en;
		logic mr_en;
		logic int_b_en;
		logic int_a_en;
	} pxc_ctrl_s;

endpackage

// ===== rtl/pxc_pin_port.sv
`timescale 1ns/1ps

module pxc_pin_port
	import pxc_pkg::*;
#(
	parameter int W = 8
) (
	// clock and reset
	input wire logic mclk,
	input wire logic arst_n,
	// effective direction and output level
	input wire logic [W-1:0] dir,
	input wire logic [W-1:0] dout,
	// pins
	input wire logic [W-1:0] pin_in,
	output logic [W-1:0] pin_out_q,
	output logic [W-1:0] pin_oe_q,
	// read view of the port
	output logic [W-1:0] rd_val
);

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge mclk or negedge arst_n) begin
				if (!arst_n) begin
					pin_out_q[i] <= 1'b0;
					pin_oe_q[i] <= 1'b0;
				end else begin
					pin_out_q[i] <= dout[i];
					pin_oe_q[i] <= dir[i];
				end
			end
			assign rd_val[i] = dir[i] ? dout[i] : pin_in[i];
		end
	endgenerate

endmodule

// ===== rtl/pxc_ready_stretch.sv
`timescale 1ns/1ps

module pxc_ready_stretch
	import pxc_pkg::*;
#(
	parameter int MAX_CYC = PXC_MR_MAX_CYC
) (
	// clock and reset
	input wire logic mclk,
	input wire logic arst_n,
	// control
	input wire logic enable,
	input wire logic ext_access,
	input wire logic ready_n_pin,
	// stretch request
	output logic stretch_q
);

	logic [7:0] cnt_q;
	logic want;

	// internal accesses never wait, so they keep full speed
	assign want = enable && ext_access && !ready_n_pin;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_q <= 8'h00;
		end else if (!want) begin
			cnt_q <= 8'h00;
		end else if (cnt_q != 8'(MAX_CYC)) begin
			cnt_q <= cnt_q + 8'h01;
		end
	end

	// a stuck pin cannot hold the clock beyond the longest stretch
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			stretch_q <= 1'b0;
		end else begin
			stretch_q <= want && (cnt_q < 8'(MAX_CYC));
		end
	end

endmodule

// ===== rtl/pxc_ports.sv
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////
module pxc_ports
	import pxc_pkg::*;
#(
	parameter int MR_MAX_CYC = PXC_MR_MAX_CYC
) (
	// clock and resets
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic stby_arst_n,

	// internal cpu bus
	input wire logic [4:0] bus_addr,
	input wire logic bus_wr,
	input wire logic bus_rd,
	input wire logic [7:0] bus_wdata,
	output logic [7:0] bus_rdata_q,

	// port a pins and function overrides
	input wire logic [7:0] port_a_in,
	output logic [7:0] port_a_out_q,
	output logic [7:0] port_a_oe_q,
	input wire pxc_func_s port_a_func,

	// input port pins
	input wire logic [7:0] input_port_in,

	// port c pins
	input wire logic [7:0] port_c_in,
	output logic [7:0] port_c_out_q,
	output logic [7:0] port_c_oe_q,

	// system side
	input wire logic ext_access,
	input wire logic standby_power_lost,
	output logic external_int_a_req_q,
	output logic external_int_b_req_q,
	output logic halt_req_q,
	output logic memory_ready_stretch_q,
	output logic onchip_ram_enable_q
);

	//////////////////////////////////////////////////////////////////////////
	// decode

	logic hit_pa_dir;
	logic hit_pa_data;
	logic hit_ctrl;
	logic hit_pb_data;
	logic hit_pc_dir;
	logic hit_pc_data;

	assign hit_pa_dir = bus_addr == PXC_OFS_PA_DIR;
	assign hit_pa_data = bus_addr == PXC_OFS_PA_DATA;
	assign hit_ctrl = bus_addr == PXC_OFS_CTRL;
	assign hit_pb_data = bus_addr == PXC_OFS_PB_DATA;
	assign hit_pc_dir = bus_addr == PXC_OFS_PC_DIR;
	assign hit_pc_data = bus_addr == PXC_OFS_PC_DATA;

	//////////////////////////////////////////////////////////////////////////
	// port a registers

	logic [1:0] pa_dir_q;
	logic [7:0] pa_data_q;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			pa_dir_q <= PXC_RST_PA_DIR;
		end else if (bus_wr && hit_pa_dir) begin
			pa_dir_q <= bus_wdata[1:0];
		end
	end

	// data latch cleared so reads are deterministic after reset
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			pa_data_q <= PXC_RST_PORT_DATA;
		end else if (bus_wr && hit_pa_data) begin
			pa_data_q <= bus_wdata;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// port a effective direction

	logic [7:0] pa_reg_dir;
	logic [7:0] pa_dir_eff;
	logic [7:0] pa_out_eff;
	logic [7:0] pa_rd;

	assign pa_reg_dir = {{7{pa_dir_q[PXC_PA_DIR_HIGH]}}, pa_dir_q[PXC_PA_DIR_PIN0]};

	genvar b;
	generate
		for (b = 0; b < 8; b++) begin : g_pa
			if (b == 0) begin : g_pin0
				// pin 0 always follows its own direction bit
				assign pa_dir_eff[b] = pa_reg_dir[b];
				assign pa_out_eff[b] = pa_data_q[b];
			end else begin : g_pinx
				assign pa_dir_eff[b] = port_a_func.take[b] ? port_a_func.dir[b] : pa_reg_dir[b];
				assign pa_out_eff[b] = port_a_func.take[b] ? port_a_func.dout[b] : pa_data_q[b];
			end
		end
	endgenerate

	pxc_pin_port #(
		.W(8)
	) u_port_a (
		.mclk(mclk),
		.arst_n(arst_n),
		.dir(pa_dir_eff),
		.dout(pa_out_eff),
		.pin_in(port_a_in),
		.pin_out_q(port_a_out_q),
		.pin_oe_q(port_a_oe_q),
		.rd_val(pa_rd)
	);

	//////////////////////////////////////////////////////////////////////////
	// port c registers

	logic [7:0] pc_dir_q;
	logic [7:0] pc_data_q;
	logic [7:0] pc_rd;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			pc_dir_q <= PXC_RST_PC_DIR;
		end else if (bus_wr && hit_pc_dir) begin
			pc_dir_q <= bus_wdata;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			pc_data_q <= PXC_RST_PORT_DATA;
		end else if (bus_wr && hit_pc_data) begin
			pc_data_q <= bus_wdata;
		end
	end

	pxc_pin_port #(
		.W(8)
	) u_port_c (
		.mclk(mclk),
		.arst_n(arst_n),
		.dir(pc_dir_q),
		.dout(pc_data_q),
		.pin_in(port_c_in),
		.pin_out_q(port_c_out_q),
		.pin_oe_q(port_c_oe_q),
		.rd_val(pc_rd)
	);

	//////////////////////////////////////////////////////////////////////////
	// control register

	logic int_a_en_q;
	logic int_b_en_q;
	logic mr_en_q;
	logic halt_en_q;
	logic ram_en_q;
	logic stby_q;
	logic ctrl_wr;
	pxc_ctrl_s ctrl_q;

	assign ctrl_wr = bus_wr && hit_ctrl;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			int_a_en_q <= 1'b0;
			int_b_en_q <= 1'b0;
		end else if (ctrl_wr) begin
			int_a_en_q <= bus_wdata[PXC_CTL_INT_A];
			int_b_en_q <= bus_wdata[PXC_CTL_INT_B];
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			mr_en_q <= 1'b1;
		end else if (ctrl_wr) begin
			mr_en_q <= bus_wdata[PXC_CTL_MR];
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			halt_en_q <= 1'b1;
		end else if (ctrl_wr) begin
			halt_en_q <= bus_wdata[PXC_CTL_HALT];
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			ram_en_q <= 1'b1;
		end else if (ctrl_wr) begin
			ram_en_q <= bus_wdata[PXC_CTL_RAM];
		end
	end

	// standby flag lives on the standby supply, so system reset leaves it
	// supply loss beats a software set in the same cycle
	// cleared on supply loss
	always_ff @(posedge mclk or negedge stby_arst_n) begin
		if (!stby_arst_n) begin
			stby_q <= 1'b0;
		end else if (standby_power_lost) begin
			stby_q <= 1'b0;
		end else if (ctrl_wr) begin
			stby_q <= bus_wdata[PXC_CTL_STBY];
		end
	end

	// one view of all fields; each field keeps a single driving process
	assign ctrl_q = {stby_q, ram_en_q, halt_en_q, mr_en_q, int_b_en_q, int_a_en_q};

	logic [7:0] ctrl_rd;

	always_comb begin
		ctrl_rd = 8'h30;
		ctrl_rd[PXC_CTL_INT_A] = ctrl_q.int_a_en;
		ctrl_rd[PXC_CTL_INT_B] = ctrl_q.int_b_en;
		ctrl_rd[PXC_CTL_MR] = ctrl_q.mr_en;
		ctrl_rd[PXC_CTL_HALT] = ctrl_q.halt_en;
		ctrl_rd[PXC_CTL_RAM] = ctrl_q.ram_en;
		ctrl_rd[PXC_CTL_STBY] = ctrl_q.stby;
	end

	//////////////////////////////////////////////////////////////////////////
	// input port functions

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			external_int_a_req_q <= 1'b0;
			external_int_b_req_q <= 1'b0;
		end else begin
			external_int_a_req_q <= ctrl_q.int_a_en && !input_port_in[PXC_PB_INT_A];
			external_int_b_req_q <= ctrl_q.int_b_en && !input_port_in[PXC_PB_INT_B];
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			halt_req_q <= 1'b0;
		end else begin
			halt_req_q <= ctrl_q.halt_en && !input_port_in[PXC_PB_HALT];
		end
	end

	pxc_ready_stretch #(
		.MAX_CYC(MR_MAX_CYC)
	) u_ready (
		.mclk(mclk),
		.arst_n(arst_n),
		.enable(ctrl_q.mr_en),
		.ext_access(ext_access),
		.ready_n_pin(input_port_in[PXC_PB_MR]),
		.stretch_q(memory_ready_stretch_q)
	);

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			onchip_ram_enable_q <= 1'b1;
		end else begin
			onchip_ram_enable_q <= ctrl_q.ram_en;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// read mux

	logic [7:0] rd_mux;

	always_comb begin
		rd_mux = PXC_UNMAPPED_READ;
		unique case (1'b1)
			hit_pa_dir: rd_mux = PXC_WO_READ;
			hit_pc_dir: rd_mux = PXC_WO_READ;
			hit_pa_data: rd_mux = pa_rd;
			hit_pc_data: rd_mux = pc_rd;
			// raw pins are read even where a pin serves an alternate use
			// input port read only
			hit_pb_data: rd_mux = input_port_in;
			hit_ctrl: rd_mux = ctrl_rd;
			default: rd_mux = PXC_UNMAPPED_READ;
		endcase
	end

	// read data held until the next read
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			bus_rdata_q <= 8'h00;
		end else if (bus_rd) begin
			bus_rdata_q <= rd_mux;
		end
	end

endmodule

// ===== dv/pxc_pins_model.sv
`timescale 1ns/1ps

module pxc_pins_model (
	// device side
	input wire logic [7:0] oe,
	input wire logic [7:0] dout,
	// outside level
	input wire logic [7:0] ext,
	output logic [7:0] pin
);
	// no pull on these pins, so the outside circuit drives every pin whose oe is low
	assign pin = (oe & dout) | (~oe & ext);
endmodule

// ===== dv/pxc_ports_checker.sv
`timescale 1ns/1ps

module pxc_ports_checker
	import pxc_pkg::*;
#(
	parameter int MR_MAX_CYC = PXC_MR_MAX_CYC
) (
	// clock and reset
	input wire logic mclk,
	input wire logic arst_n,
	// bus
	input wire logic [4:0] bus_addr,
	input wire logic bus_wr,
	input wire logic bus_rd,
	input wire logic [7:0] bus_rdata_q,
	// pins
	input wire logic [7:0] port_a_out_q,
	input wire logic [7:0] port_a_oe_q,
	input wire pxc_func_s port_a_func,
	input wire logic [7:0] input_port_in,
	// system
	input wire logic ext_access,
	input wire logic external_int_a_req_q,
	input wire logic external_int_b_req_q,
	input wire logic halt_req_q,
	input wire logic memory_ready_stretch_q,
	input wire logic onchip_ram_enable_q
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);
	logic [7:0] st_cnt_q;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n)
			st_cnt_q <= 8'h00;
		else
			st_cnt_q <= memory_ready_stretch_q ? st_cnt_q + 8'h01 : 8'h00;
	end

	wo_read_ff_a: assert property (bus_rd && (bus_addr == PXC_OFS_PA_DIR || bus_addr == PXC_OFS_PC_DIR)
		|=> bus_rdata_q == PXC_WO_READ) else $error("direction read not FF");
	int_a_cause_a: assert property (external_int_a_req_q |->
		!$past(input_port_in[0]) || !$past(input_port_in[0], 2)) else $error("int a without low pin");
	int_b_cause_a: assert property (external_int_b_req_q |->
		!$past(input_port_in[1]) || !$past(input_port_in[1], 2)) else $error("int b without low pin");
	halt_cause_a: assert property (halt_req_q |->
		!$past(input_port_in[3]) || !$past(input_port_in[3], 2)) else $error("halt without low pin");
	stretch_cause_a: assert property (memory_ready_stretch_q |->
		$past(ext_access) && !$past(input_port_in[2])) else $error("stretch without cause");
	stretch_cap_a: assert property (st_cnt_q <= MR_MAX_CYC) else $error("stretch too long");
	pa_group_a: assert property (port_a_func.take[7:1] == 7'h00 && $past(port_a_func.take[7:1]) == 7'h00
		|-> port_a_oe_q[7:1] == 7'h00 || port_a_oe_q[7:1] == 7'h7F) else $error("port a pins split");
	func_dir_a: assert property (($past(port_a_func.take[7:1]) &
		(port_a_oe_q[7:1] ^ $past(port_a_func.dir[7:1]))) == 7'h00) else $error("function dir ignored");
	func_out_a: assert property (($past(port_a_func.take[7:1]) &
		(port_a_out_q[7:1] ^ $past(port_a_func.dout[7:1]))) == 7'h00) else $error("function level ignored");
	ram_by_write_a: assert property ($changed(onchip_ram_enable_q) |->
		$past(bus_wr && bus_addr == PXC_OFS_CTRL) || $past(bus_wr && bus_addr == PXC_OFS_CTRL, 2))
		else $error("ram enable moved alone");

	cover property (memory_ready_stretch_q);
	cover property (external_int_a_req_q && halt_req_q);
	cover property (bus_rd && bus_addr == PXC_OFS_CTRL);
endmodule

bind pxc_ports pxc_ports_checker #(.MR_MAX_CYC(MR_MAX_CYC)) u_pxc_chk (.mclk, .arst_n, .bus_addr, .bus_wr,
	.bus_rd, .bus_rdata_q, .port_a_out_q, .port_a_oe_q, .port_a_func, .input_port_in, .ext_access,
	.external_int_a_req_q, .external_int_b_req_q, .halt_req_q, .memory_ready_stretch_q, .onchip_ram_enable_q);

// ===== dv/pxc_ports_bench.sv
`timescale 1ns/1ps

module pxc_ports_bench
	import pxc_pkg::*;
;
	logic mclk, arst_n, stby_arst_n, bus_wr, bus_rd, ext_access, standby_power_lost;
	logic int_a, int_b, halt, mr_st, ram_en;
	logic [4:0] bus_addr;
	logic [7:0] bus_wdata, bus_rdata_q, pa_in, pa_out, pa_oe, ip, pc_in, pc_out, pc_oe, ea, ec;
	logic [1:0] pa_dir;
	logic [7:0] pa_d, pc_dir, pc_d, ctl, m;
	logic [4:0] ofs [8] = '{PXC_OFS_PA_DIR, PXC_OFS_PA_DATA, PXC_OFS_CTRL, PXC_OFS_PB_DATA,
		PXC_OFS_PC_DIR, PXC_OFS_PC_DATA, 5'h00, 5'h1F};
	pxc_func_s fn;
	int fail_count, comparisons, cyc, seed, j;

	pxc_ports #(.MR_MAX_CYC(4)) dut (.mclk(mclk), .arst_n(arst_n), .stby_arst_n(stby_arst_n),
		.bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata_q(bus_rdata_q),
		.port_a_in(pa_in), .port_a_out_q(pa_out), .port_a_oe_q(pa_oe), .port_a_func(fn), .input_port_in(ip),
		.port_c_in(pc_in), .port_c_out_q(pc_out), .port_c_oe_q(pc_oe), .ext_access(ext_access),
		.standby_power_lost(standby_power_lost), .external_int_a_req_q(int_a), .external_int_b_req_q(int_b),
		.halt_req_q(halt), .memory_ready_stretch_q(mr_st), .onchip_ram_enable_q(ram_en));
	pxc_pins_model pa_m (.oe(pa_oe), .dout(pa_out), .ext(ea), .pin(pa_in));
	pxc_pins_model pc_m (.oe(pc_oe), .dout(pc_out), .ext(ec), .pin(pc_in));

	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	always @(posedge mclk) begin
		cyc++;
		if (cyc > 5000) begin
			fail_count++;
			tally_and_finish;
		end
	end

	////////////////////////////////////////
	task tally_and_finish;
		$display("mismatches %0d comparisons %0d", fail_count, comparisons);
		if (fail_count == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task chk(input logic [7:0] g, input logic [7:0] e);
		comparisons++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask

	function logic [7:0] expv(input logic [4:0] a);
		m = {{7{pa_dir[1]}}, pa_dir[0]};
		case (a)
			PXC_OFS_PA_DATA: expv = (pa_d & m) | (ea & ~m);
			PXC_OFS_CTRL: expv = ctl | 8'h30;
			PXC_OFS_PB_DATA: expv = ip;
			PXC_OFS_PC_DATA: expv = (pc_d & pc_dir) | (ec & ~pc_dir);
			default: expv = 8'hFF;
		endcase
	endfunction

	task wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge mclk);
		bus_addr <= a;
		bus_wdata <= d;
		bus_wr <= 1'b1;
		@(posedge mclk);
		bus_wr <= 1'b0;
		case (a)
			PXC_OFS_PA_DIR: pa_dir = d[1:0];
			PXC_OFS_PA_DATA: pa_d = d;
			PXC_OFS_CTRL: ctl = d & 8'hCF;
			PXC_OFS_PC_DIR: pc_dir = d;
			PXC_OFS_PC_DATA: pc_d = d;
			default: ;
		endcase
	endtask

	task rd(input logic [4:0] a, input logic [7:0] e);
		@(posedge mclk);
		bus_addr <= a;
		bus_rd <= 1'b1;
		@(posedge mclk);
		bus_rd <= 1'b0;
		@(posedge mclk);
		@(negedge mclk);
		chk(bus_rdata_q, e);
	endtask

	task pins;
		repeat (2) @(posedge mclk);
		@(negedge mclk);
		m = {{7{pa_dir[1]}}, pa_dir[0]};
		chk(pa_oe, m);
		chk(pa_out & m, pa_d & m);
		chk(pc_oe, pc_dir);
		chk(pc_out & pc_dir, pc_d & pc_dir);
	endtask

	task rst;
		@(posedge mclk);
		arst_n <= 1'b0;
		repeat (8) @(posedge mclk);
		arst_n <= 1'b1;
		pa_dir = 2'h0;
		pa_d = 8'h00;
		pc_dir = 8'h00;
		pc_d = 8'h00;
		ctl = {ctl[7], 7'h4C};
	endtask

	////////////////////////////////////////
	initial begin
		seed = 32'h6a99487e;
		{fail_count, comparisons, cyc} = 0;
		{arst_n, stby_arst_n, bus_wr, bus_rd, ext_access, standby_power_lost} = 6'h00;
		{bus_addr, bus_wdata, ctl} = 21'h0;
		fn = '0;
		ea = 8'hA5;
		ec = 8'h3C;
		ip = 8'hFF;
		rst;
		stby_arst_n <= 1'b1;
		pins;
		rd(PXC_OFS_CTRL, 8'h7C);
		chk({7'h0, ram_en}, 8'h01);
		wr(PXC_OFS_CTRL, 8'h40);
		repeat (40) begin
			@(posedge mclk);
			ea <= 8'($random(seed));
			ec <= 8'($random(seed));
			ip <= 8'($random(seed));
			j = $random(seed) & 7;
			wr(ofs[j], 8'($random(seed)));
			pins;
			j = $random(seed) & 7;
			rd(ofs[j], expv(ofs[j]));
		end
		for (int v = 0; v < 16; v++) begin
			wr(PXC_OFS_CTRL, 8'h40 | 8'(v));
			ip <= 8'hF0;
			ext_access <= 1'b1;
			repeat (3) @(posedge mclk);
			@(negedge mclk);
			chk({mr_st, halt, int_b, int_a}, {v[2], v[3], v[1], v[0]});
			@(posedge mclk);
			ip <= 8'hFF;
		end
		wr(PXC_OFS_CTRL, 8'h44);
		ip <= 8'hFB;
		ext_access <= 1'b1;
		repeat (2) @(posedge mclk);
		@(negedge mclk);
		chk({7'h0, mr_st}, 8'h01);
		repeat (8) @(posedge mclk);
		@(negedge mclk);
		chk({7'h0, mr_st}, 8'h00);
		wr(PXC_OFS_CTRL, 8'h40);
		ext_access <= 1'b0;
		ip <= 8'hFF;
		wr(PXC_OFS_PA_DIR, 8'h01);
		fn <= 24'($random(seed));
		repeat (2) @(posedge mclk);
		@(negedge mclk);
		m = {fn.take[7:1], 1'b0};
		chk(pa_oe, (m & fn.dir) | (~m & 8'h01));
		@(posedge mclk);
		fn <= '0;
		// ram off and standby set in the same write
		wr(PXC_OFS_CTRL, 8'h80);
		rd(PXC_OFS_CTRL, expv(PXC_OFS_CTRL));
		chk({7'h0, ram_en}, 8'h00);
		rst;
		rd(PXC_OFS_CTRL, 8'hFC);
		pins;
		@(posedge mclk);
		standby_power_lost <= 1'b1;
		@(posedge mclk);
		standby_power_lost <= 1'b0;
		ctl = ctl & 8'h7F;
		rd(PXC_OFS_CTRL, expv(PXC_OFS_CTRL));
		tally_and_finish;
	end
endmodule
